// ### rtl/jlm_rx_link.sv
// Purpose: Lane FIFOs, crossbar, inversion, 8b/10b decode, descrambler and LMFC sync engine.
// Assumes: One clock serves as processing and device clock; inputs synchronous to it.
// Notes:   Functional notes below.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module jlm_lane_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,    // Clock
  input  wire logic             rst,        // Sync reset, active high
  input  wire logic             in_valid,   // Write request
  input  wire logic [WIDTH-1:0] in_data,    // Write data
  output var  logic             in_ready,   // Space available
  output var  logic             out_valid,  // Data available
  output var  logic [WIDTH-1:0] out_data,   // Head word
  input  wire logic             out_ready,  // Pop request
  output var  logic             full,       // All slots used
  output var  logic             empty       // No slot used
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("jlm_lane_fifo: DEPTH must be >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
    logic                        full;
    logic                        empty;
  } fifo_st_t;

  fifo_st_t s_reg;
  fifo_st_t s_next;
  logic     push;
  logic     pop;

  always_comb begin
    s_next = s_reg;
    push   = in_valid && !s_reg.full;
    pop    = out_ready && !s_reg.empty;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data;
      s_next.wp            = (s_reg.wp == LAST) ? '0 : s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = (s_reg.rp == LAST) ? '0 : s_reg.rp + 1'b1;
    end
    s_next.cnt   = s_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
    s_next.full  = (s_next.cnt == (PW+1)'(DEPTH));
    s_next.empty = (s_next.cnt == '0);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_reg       <= '0;
      s_reg.empty <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign in_ready  = !s_reg.full;
  assign out_valid = !s_reg.empty;
  assign out_data  = s_reg.mem[s_reg.rp];
  assign full      = s_reg.full;
  assign empty     = s_reg.empty;
endmodule // jlm_lane_fifo

////////////////////////////////////////////////////////////////////////////////
module jlm_rx_link #(
  parameter int LMFC_PERIOD = jlm_pkg::LMFC_PERIOD_DEF,
  parameter int ROT_CYCLES  = jlm_pkg::ROT_CYCLES_DEF,
  parameter int FIFO_DEPTH  = jlm_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic                                     sys_clk,      // Clock, 200 MHz
  input  wire logic                                     rst,          // Sync reset
  input  wire jlm_pkg::jlm_reg_req_t                    reg_req,      // Register access
  output var  logic [7:0]                               reg_rdata,    // Read data
  input  wire logic [jlm_pkg::NUM_LANES-1:0]            lane_valid,   // Lane word valid
  input  wire logic [jlm_pkg::NUM_LANES-1:0][39:0]      lane_sym,     // Four 10b symbols
  output var  logic [jlm_pkg::NUM_LANES-1:0]            lane_ready,   // Lane FIFO space
  input  wire logic                                     sysref,       // Alignment pulse
  input  wire logic                                     subclass_one, // 1: SYSREF edges
  output var  logic                                     out_valid,    // Octets valid
  output var  jlm_pkg::jlm_octets_t [jlm_pkg::NUM_LANES-1:0] out_lanes, // Logical lanes
  input  wire logic                                     out_ready,    // Sink accepts
  output var  logic                                     fifo_irq,     // FIFO error irq
  output var  logic                                     lmfc_edge     // LMFC boundary
);
  localparam int NL = jlm_pkg::NUM_LANES;
  localparam logic [7:0] P_LAST = 8'(LMFC_PERIOD - 1);
  localparam logic [7:0] P_HALF = 8'(LMFC_PERIOD / 2);
  localparam logic [7:0] ROT_LAST = 8'(ROT_CYCLES - 1);

  initial begin
    if (LMFC_PERIOD < 4 || LMFC_PERIOD > 256) $error("jlm_rx_link: LMFC_PERIOD 4..256");
    if (ROT_CYCLES < 1 || ROT_CYCLES > 256) $error("jlm_rx_link: ROT_CYCLES 1..256");
    if (FIFO_DEPTH < 4) $error("jlm_rx_link: FIFO_DEPTH too small for drift");
  end

  typedef struct packed {
    logic [7:0]                   irq_en;
    logic [7:0]                   irq_st;
    logic [7:0]                   win;
    logic [7:0]                   err_snap;
    logic [7:0]                   flag_snap;
    logic [7:0]                   ctrl;
    logic [7:0]                   stat;
    logic [7:0]                   cur_lo;
    logic [7:0]                   cur_hi;
    logic [7:0]                   xbar01;
    logic [7:0]                   xbar23;
    logic [7:0]                   inv;
    logic [7:0]                   descramble_enable;
    logic [7:0]                   rdata;
    logic                         sysref_q;
    logic                         sysref_qq;
    logic [7:0]                   lmfc_cnt;
    logic [7:0]                   sc0_cnt;
    logic                         lmfc_edge;
    jlm_pkg::jlm_eng_state_t      eng;
    logic [7:0]                   rot_cnt;
    logic [NL-1:0][14:0]          scr_st;
    logic                         out_valid;
    jlm_pkg::jlm_octets_t [NL-1:0] out;
    logic                         irq;
  } st_t;

  st_t s_reg;
  st_t s_next;

  ////////////////////////////////////////////////////////////////////////////////
  // 8b/10b decode helpers: dec6 gives {ok, k28, value}, dec4 gives {ok, value}
  function automatic logic [6:0] dec6(input logic [5:0] c);
    unique case (c)
      6'h27, 6'h18: dec6 = 7'h40;
      6'h1D, 6'h22: dec6 = 7'h41;
      6'h2D, 6'h12: dec6 = 7'h42;
      6'h31:        dec6 = 7'h43;
      6'h35, 6'h0A: dec6 = 7'h44;
      6'h29:        dec6 = 7'h45;
      6'h19:        dec6 = 7'h46;
      6'h38, 6'h07: dec6 = 7'h47;
      6'h39, 6'h06: dec6 = 7'h48;
      6'h25:        dec6 = 7'h49;
      6'h15:        dec6 = 7'h4A;
      6'h34:        dec6 = 7'h4B;
      6'h0D:        dec6 = 7'h4C;
      6'h2C:        dec6 = 7'h4D;
      6'h1C:        dec6 = 7'h4E;
      6'h17, 6'h28: dec6 = 7'h4F;
      6'h1B, 6'h24: dec6 = 7'h50;
      6'h23:        dec6 = 7'h51;
      6'h13:        dec6 = 7'h52;
      6'h32:        dec6 = 7'h53;
      6'h0B:        dec6 = 7'h54;
      6'h2A:        dec6 = 7'h55;
      6'h1A:        dec6 = 7'h56;
      6'h3A, 6'h05: dec6 = 7'h57;
      6'h33, 6'h0C: dec6 = 7'h58;
      6'h26:        dec6 = 7'h59;
      6'h16:        dec6 = 7'h5A;
      6'h36, 6'h09: dec6 = 7'h5B;
      6'h0E:        dec6 = 7'h5C;
      6'h2E, 6'h11: dec6 = 7'h5D;
      6'h1E, 6'h21: dec6 = 7'h5E;
      6'h2B, 6'h14: dec6 = 7'h5F;
      6'h0F, 6'h30: dec6 = 7'h7C;
      default:      dec6 = 7'h00;
    endcase
  endfunction

  function automatic logic [3:0] dec4(input logic [3:0] c);
    unique case (c)
      4'hB, 4'h4:             dec4 = 4'h8;
      4'h9:                   dec4 = 4'h9;
      4'h5:                   dec4 = 4'hA;
      4'hC, 4'h3:             dec4 = 4'hB;
      4'hD, 4'h2:             dec4 = 4'hC;
      4'hA:                   dec4 = 4'hD;
      4'h6:                   dec4 = 4'hE;
      4'hE, 4'h1, 4'h7, 4'h8: dec4 = 4'hF;
      default:                dec4 = 4'h0;
    endcase
  endfunction

  function automatic logic [46:0] descramble(input logic [14:0] st, input logic [31:0] d);
    logic [14:0] s;
    logic [31:0] o;
    s = st;
    o = '0;
    for (int i = 31; i >= 0; i--) begin
      o[i] = d[i] ^ s[13] ^ s[14];
      s    = {s[13:0], d[i]};
    end
    descramble = {s, o};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // one elastic FIFO per physical lane
  logic [NL-1:0]           f_valid;
  logic [NL-1:0]           f_full;
  logic [NL-1:0]           f_empty;
  logic [NL-1:0][39:0]     f_data;
  logic                    pop;

  for (genvar g = 0; g < NL; g++) begin : g_fifo
    jlm_lane_fifo #(.WIDTH(40), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (lane_valid[g]),
      .in_data   (lane_sym[g]),
      .in_ready  (lane_ready[g]),
      .out_valid (f_valid[g]),
      .out_data  (f_data[g]),
      .out_ready (pop),
      .full      (f_full[g]),
      .empty     (f_empty[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic        wr;
  logic        edge_in;
  logic        edge_ok;
  logic        armed;
  logic        checking;
  logic        may_align;
  logic        rotate;
  logic        out_win;
  logic        fifo_err;
  logic [7:0]  perr;
  logic [7:0]  pabs;
  logic [7:0]  flags;
  logic [3:0]  mode;
  logic [2:0]  src;
  logic [39:0] sym;
  logic [6:0]  d6;
  logic [3:0]  d4;
  logic [46:0] dsc;
  jlm_pkg::jlm_octets_t dec;

  always_comb begin
    s_next = s_reg;
    wr     = reg_req.wr_en;
    mode   = s_reg.ctrl[jlm_pkg::MODE_W-1:0];
    pop    = (&f_valid) && (!s_reg.out_valid || out_ready);
    src    = '0;
    sym    = '0;
    d6     = '0;
    d4     = '0;
    dsc    = '0;
    dec    = '0;

    // overflow on any lane; set wins over write-one-clear
    fifo_err = |(lane_valid & f_full);
    if (wr && reg_req.addr == jlm_pkg::OFS_FIFO_IRQ_ST) begin
      s_next.irq_st[jlm_pkg::FIFO_ERR_BIT] =
        s_reg.irq_st[jlm_pkg::FIFO_ERR_BIT] & ~reg_req.wdata[jlm_pkg::FIFO_ERR_BIT];
    end
    if (fifo_err) begin
      s_next.irq_st[jlm_pkg::FIFO_ERR_BIT] = 1'b1;
    end
    s_next.irq = s_next.irq_st[jlm_pkg::FIFO_ERR_BIT] & s_reg.irq_en[jlm_pkg::FIFO_ERR_BIT];

    // four octets per lane on each pop
    if (out_ready) begin
      s_next.out_valid = 1'b0;
    end
    if (pop) begin
      s_next.out_valid = 1'b1;
      for (int l = 0; l < NL; l++) begin
        src = (l < 2) ? s_reg.xbar01[(l % 2) * jlm_pkg::XBAR_W +: jlm_pkg::XBAR_W]
                      : s_reg.xbar23[(l % 2) * jlm_pkg::XBAR_W +: jlm_pkg::XBAR_W];
        // Sources at or above the lane count feed idle zeros
        sym = (src < 3'(NL)) ? f_data[src[1:0]] : '0;
        if (s_reg.inv[l]) begin
          sym = ~sym;
        end
        for (int j = 0; j < jlm_pkg::OCTETS; j++) begin
          d6 = dec6(sym[10*j+4 +: 6]);
          d4 = dec4(sym[10*j +: 4]);
          dec.data[8*j +: 8] = {d4[2:0], d6[4:0]};
          dec.k[j]           = d6[5];
          dec.code_err[j]    = !(d6[6] && d4[3]);
        end
        // same register stage whether or not descrambling
        dsc = descramble(s_reg.scr_st[l], dec.data);
        s_next.scr_st[l] = dsc[46:32];
        if (s_reg.descramble_enable[jlm_pkg::SCR_EN_BIT]) begin
          dec.data = dsc[31:0];
        end
        s_next.out[l] = dec;
      end
    end

    // SYSREF taken high on the rising clock edge
    s_next.sysref_q  = sysref;
    s_next.sysref_qq = s_reg.sysref_q;
    s_next.sc0_cnt   = (s_reg.sc0_cnt == P_LAST) ? '0 : s_reg.sc0_cnt + 8'h01;
    s_next.lmfc_cnt  = (s_reg.lmfc_cnt == P_LAST) ? '0 : s_reg.lmfc_cnt + 8'h01;
    s_next.lmfc_edge = (s_next.lmfc_cnt == '0);

    // edge source by subclass; any rising edge counts
    edge_in = subclass_one ? (s_reg.sysref_q && !s_reg.sysref_qq) : (s_reg.sc0_cnt == '0);
    // no edges taken while rotating; enable gates every edge
    edge_ok = edge_in && s_reg.ctrl[jlm_pkg::CTRL_ENABLE_BIT] &&
              (s_reg.eng == jlm_pkg::ENG_READY);
    armed   = s_reg.ctrl[jlm_pkg::CTRL_ARM_BIT];

    // signed distance of LMFC from the edge
    perr = (s_reg.lmfc_cnt < P_HALF) ? s_reg.lmfc_cnt : s_reg.lmfc_cnt - 8'(LMFC_PERIOD);
    pabs = perr[7] ? (8'h00 - perr) : perr;
    // zero code means zero tolerance, any error is outside
    out_win = (s_reg.win[jlm_pkg::TOL_W-1:0] == '0) ? (perr != '0) :
              (pabs > {5'h00, s_reg.win[jlm_pkg::TOL_W-1:0]});
    flags = '0;
    flags[jlm_pkg::FLAG_LOW_BIT]  = out_win && perr[7];
    flags[jlm_pkg::FLAG_HIGH_BIT] = out_win && !perr[7];

    // one-shot needs arming; continuous always; monitor always measures
    checking  = edge_ok && ((mode == jlm_pkg::MODE_CONT) || (mode == jlm_pkg::MODE_MONITOR) ||
                            (mode == jlm_pkg::MODE_ONE_SHOT && armed));
    may_align = (mode == jlm_pkg::MODE_CONT) ||
                (armed && (mode == jlm_pkg::MODE_ONE_SHOT || mode == jlm_pkg::MODE_MONITOR));
    rotate    = checking && may_align && out_win;

    if (checking) begin
      s_next.stat[jlm_pkg::STAT_LOCK_BIT] = !out_win || rotate;
      s_next.stat[jlm_pkg::STAT_WLIM_BIT] = out_win && !rotate;
      // report the error measured at this edge, unless it rotates
      s_next.cur_lo = perr;
      s_next.cur_hi = flags;
    end
    if (rotate) begin
      s_next.err_snap  = perr;
      s_next.flag_snap = flags;
      s_next.cur_lo    = '0;
      s_next.cur_hi    = '0;
      s_next.lmfc_cnt  = 8'h01;
      s_next.lmfc_edge = 1'b0;
      s_next.eng       = jlm_pkg::ENG_ROTATE;
      s_next.rot_cnt   = ROT_LAST;
    end else if (s_reg.eng == jlm_pkg::ENG_ROTATE) begin
      if (s_reg.rot_cnt == '0) begin
        s_next.eng = jlm_pkg::ENG_READY;
      end else begin
        s_next.rot_cnt = s_reg.rot_cnt - 8'h01;
      end
    end
    s_next.stat[jlm_pkg::STAT_BUSY_BIT] = (s_next.eng == jlm_pkg::ENG_ROTATE);

    // Register writes; write-only clear bit never stored
    if (wr) begin
      unique case (reg_req.addr)
        jlm_pkg::OFS_FIFO_IRQ_EN: s_next.irq_en = reg_req.wdata;
        jlm_pkg::OFS_PHASE_WIN:   s_next.win    = reg_req.wdata;
        jlm_pkg::OFS_XBAR_01:     s_next.xbar01 = reg_req.wdata;
        jlm_pkg::OFS_XBAR_23:     s_next.xbar23 = reg_req.wdata;
        jlm_pkg::OFS_LANE_INV:    s_next.inv    = reg_req.wdata;
        jlm_pkg::OFS_SCR_CFG:     s_next.descramble_enable    = reg_req.wdata;
        jlm_pkg::OFS_ALIGN_CTRL: begin
          s_next.ctrl = reg_req.wdata;
          s_next.ctrl[jlm_pkg::CTRL_CLR_BIT] = 1'b0;
          if (reg_req.wdata[jlm_pkg::CTRL_CLR_BIT]) begin
            s_next.stat[jlm_pkg::STAT_ROT_BIT]  = 1'b0;
            s_next.stat[jlm_pkg::STAT_TRIP_BIT] = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // arm self-clears on an edge unless rewritten now
    if (edge_ok && !(wr && reg_req.addr == jlm_pkg::OFS_ALIGN_CTRL)) begin
      s_next.ctrl[jlm_pkg::CTRL_ARM_BIT] = 1'b0;
    end
    // sticky flags, set wins over clear
    if (checking) begin
      s_next.stat[jlm_pkg::STAT_TRIP_BIT] = 1'b1;
    end
    if (rotate) begin
      s_next.stat[jlm_pkg::STAT_ROT_BIT] = 1'b1;
    end

    // FIFO status readback, plus all readable registers
    if (reg_req.rd_en) begin
      unique case (reg_req.addr)
        jlm_pkg::OFS_FIFO_IRQ_EN: s_next.rdata = s_reg.irq_en;
        jlm_pkg::OFS_FIFO_IRQ_ST: s_next.rdata = s_reg.irq_st;
        jlm_pkg::OFS_PHASE_WIN:   s_next.rdata = s_reg.win;
        jlm_pkg::OFS_ERR_SNAP:    s_next.rdata = s_reg.err_snap;
        jlm_pkg::OFS_FLAG_SNAP:   s_next.rdata = s_reg.flag_snap;
        jlm_pkg::OFS_ALIGN_CTRL:  s_next.rdata = s_reg.ctrl;
        jlm_pkg::OFS_ALIGN_STAT:  s_next.rdata = s_reg.stat;
        jlm_pkg::OFS_CUR_ERR_LO:  s_next.rdata = s_reg.cur_lo;
        jlm_pkg::OFS_CUR_ERR_HI:  s_next.rdata = s_reg.cur_hi;
        jlm_pkg::OFS_XBAR_01:     s_next.rdata = s_reg.xbar01;
        jlm_pkg::OFS_XBAR_23:     s_next.rdata = s_reg.xbar23;
        jlm_pkg::OFS_FIFO_FULL:   s_next.rdata = {4'h0, f_full};
        jlm_pkg::OFS_FIFO_EMPTY:  s_next.rdata = {4'h0, f_empty};
        jlm_pkg::OFS_LANE_INV:    s_next.rdata = s_reg.inv;
        jlm_pkg::OFS_SCR_CFG:     s_next.rdata = s_reg.descramble_enable;
        default:                  s_next.rdata = jlm_pkg::REG_CLEAR_RST;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_reg        <= '0;
      s_reg.xbar01 <= jlm_pkg::XBAR_01_RST;
      s_reg.xbar23 <= jlm_pkg::XBAR_23_RST;
      s_reg.eng    <= jlm_pkg::ENG_READY;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign out_valid = s_reg.out_valid;
  assign out_lanes = s_reg.out;
  assign fifo_irq  = s_reg.irq;
  assign lmfc_edge = s_reg.lmfc_edge;
endmodule // jlm_rx_link

`default_nettype wire

// ### rtl/jlm_pkg.sv
// Purpose: Shared constants and types of the JESD204B receive lane map / LMFC sync block.
// Assumes: Byte-wide register port, 12-bit register addresses.
// Notes:   Reset values not listed here read as REG_CLEAR_RST, except FIFO empty status, which reads 8'h0F.
`default_nettype none

package jlm_pkg;

  localparam int NUM_LANES = 4;
  localparam int OCTETS    = 4;
  localparam int SYM_W     = 10 * OCTETS;
  localparam int DATA_W    = 8 * OCTETS;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [11:0] OFS_FIFO_IRQ_EN  = 12'h01F;
  localparam logic [11:0] OFS_FIFO_IRQ_ST  = 12'h023;
  localparam logic [11:0] OFS_PHASE_WIN    = 12'h034;
  localparam logic [11:0] OFS_ERR_SNAP     = 12'h038;
  localparam logic [11:0] OFS_FLAG_SNAP    = 12'h039;
  localparam logic [11:0] OFS_ALIGN_CTRL   = 12'h03A;
  localparam logic [11:0] OFS_ALIGN_STAT   = 12'h03B;
  localparam logic [11:0] OFS_CUR_ERR_LO   = 12'h03C;
  localparam logic [11:0] OFS_CUR_ERR_HI   = 12'h03D;
  localparam logic [11:0] OFS_XBAR_01      = 12'h308;
  localparam logic [11:0] OFS_XBAR_23      = 12'h309;
  localparam logic [11:0] OFS_FIFO_FULL    = 12'h30C;
  localparam logic [11:0] OFS_FIFO_EMPTY   = 12'h30D;
  localparam logic [11:0] OFS_LANE_INV     = 12'h334;
  localparam logic [11:0] OFS_SCR_CFG      = 12'h453;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int FIFO_ERR_BIT    = 1;
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_ARM_BIT    = 6;
  localparam int CTRL_CLR_BIT    = 5;
  localparam int MODE_W          = 4;
  localparam int STAT_BUSY_BIT   = 7;
  localparam int STAT_LOCK_BIT   = 3;
  localparam int STAT_ROT_BIT    = 2;
  localparam int STAT_WLIM_BIT   = 1;
  localparam int STAT_TRIP_BIT   = 0;
  localparam int FLAG_LOW_BIT    = 6;
  localparam int FLAG_HIGH_BIT   = 7;
  localparam int SCR_EN_BIT      = 7;
  localparam int XBAR_LO_POS     = 0;
  localparam int XBAR_HI_POS     = 3;
  localparam int XBAR_W          = 3;
  localparam int TOL_W           = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] REG_CLEAR_RST = 8'h00;
  localparam logic [7:0] XBAR_01_RST   = 8'h08;
  localparam logic [7:0] XBAR_23_RST   = 8'h1A;

  // Alignment mode codes
  localparam logic [3:0] MODE_ONE_SHOT = 4'h1;
  localparam logic [3:0] MODE_CONT     = 4'h2;
  localparam logic [3:0] MODE_MONITOR  = 4'h9;

  // Default counts: LMFC and rotation in device clock cycles, FIFO depth in words
  localparam int LMFC_PERIOD_DEF = 32;
  localparam int ROT_CYCLES_DEF  = 4;
  localparam int FIFO_DEPTH_DEF  = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } jlm_reg_req_t;

  typedef struct packed {
    logic [OCTETS-1:0] code_err;
    logic [OCTETS-1:0] k;
    logic [DATA_W-1:0] data;
  } jlm_octets_t;

  typedef enum logic {ENG_READY, ENG_ROTATE} jlm_eng_state_t;

endpackage

`default_nettype wire

// ### verif/jlm_rx_link_properties.sv
// Purpose: Port checks of jlm_rx_link
// Assumes: LMFC period of 8 or more
// Notes: Bound to the top module
`default_nettype none
module jlm_rx_props (
  input wire logic                       sys_clk,    // Clock
  input wire logic                       rst,        // Reset
  input wire jlm_pkg::jlm_reg_req_t      reg_req,    // Register access
  input wire logic [7:0]                 reg_rdata,  // Read data
  input wire logic [3:0]                 lane_valid, // Lane valid
  input wire logic [3:0]                 lane_ready, // Lane space
  input wire logic                       out_valid,  // Octets valid
  input wire jlm_pkg::jlm_octets_t [3:0] out_lanes,  // Logical lanes
  input wire logic                       out_ready,  // Sink accepts
  input wire logic                       fifo_irq,   // Irq
  input wire logic                       lmfc_edge   // LMFC boundary
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence rd_at_s(logic [11:0] a);
    reg_req.rd_en && reg_req.addr == a;
  endsequence
  reset_clear_a: assert property (disable iff (1'b0) rst |=> !out_valid && !fifo_irq)
    else $error("outputs not cleared");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_lanes))
    else $error("stalled set changed");
  rdata_hold_a: assert property (!reg_req.rd_en |=> $stable(reg_rdata))
    else $error("read data moved");
  unmapped_zero_a: assert property (rd_at_s(12'h7FF) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  clear_strobe_a: assert property (rd_at_s(12'h03A) |=> !reg_rdata[5])
    else $error("clear bit reads one");
  ready_idle_a: assert property (
    lane_valid == 4'h0 && lane_ready == 4'hF |=> lane_ready == 4'hF)
    else $error("ready fell while idle");
  lmfc_gap_a: assert property (lmfc_edge |=> !lmfc_edge [*6])
    else $error("boundary too soon");
  irq_mask_a: assert property (
    reg_req.wr_en && reg_req.addr == 12'h01F && !reg_req.wdata[1] |-> ##2 !fifo_irq)
    else $error("masked irq raised");
endmodule // jlm_rx_props
bind jlm_rx_link jlm_rx_props u_props (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .lane_valid(lane_valid), .lane_ready(lane_ready), .out_valid(out_valid),
  .out_lanes(out_lanes), .out_ready(out_ready), .fifo_irq(fifo_irq), .lmfc_edge(lmfc_edge));
`default_nettype wire

// ### verif/jlm_tx_model.sv
// Purpose: Transmitter feeding four lanes and SYSREF
// Assumes: Neutral data codes, so inversion maps one code onto another
// Notes: Index of each word is exposed for the bench model
`default_nettype none
module jlm_tx_model (
  input  wire logic             sys_clk,    // Clock
  input  wire logic             send,       // Offer words
  input  wire logic             pulse,      // SYSREF request
  input  wire logic [3:0]       lane_ready, // Lane space
  output var  logic [3:0]       lane_valid, // Word valid
  output var  logic [3:0][39:0] lane_sym,   // Symbols
  output var  logic [7:0]       sent_idx,   // Code index per lane
  output var  logic             sysref      // Alignment pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [39:0] SYMS = {10'h166, 10'h299, 10'h0E6, 10'h319};
  int seed = 32'h5E44;
  logic [3:0] taken;
  logic       level;
  logic       go;
  initial {lane_valid, lane_sym, sent_idx, sysref} = '0;
  always @(posedge sys_clk) begin
    // Requests taken at the edge, never raced against the bench
    taken = lane_valid & lane_ready;
    level = pulse;
    go    = send;
    #1;
    sysref = level;
    // scrambling never enabled, so words go out plain
    if (lane_valid == 4'h0 || taken == 4'hF) begin
      lane_valid = {4{go}};
      sent_idx = 8'($random(seed));
      for (int l = 0; l < 4; l++)
        for (int j = 0; j < 4; j++)
          lane_sym[l][10*j +: 10] = go ? SYMS[10*((sent_idx[2*l +: 2] + j) % 4) +: 10]
                                       : ~lane_sym[l][10*j +: 10];
    end
  end
endmodule // jlm_tx_model
`default_nettype wire

// ### verif/test_jesd_rx_lane_map_lmfc_sync.sv
// Purpose: Self-checking bench of jlm_rx_link
// Assumes: LMFC_PERIOD 8, ROT_CYCLES 2
// Notes: Queue model of accepted words
`default_nettype none
module test_jesd_rx_lane_map_lmfc_sync;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] DATA = {8'hDA, 8'h25, 8'hDC, 8'h23};
  logic sys_clk = 0, rst = 1, sysref, out_valid, out_ready = 0, fifo_irq, lmfc_edge;
  logic send = 0, pulse = 0, sc1 = 1;
  logic [7:0] reg_rdata, sent_idx, rd, e, q[$];
  logic [3:0] lane_valid, lane_ready;
  logic [3:0][39:0] lane_sym, ex;
  jlm_pkg::jlm_reg_req_t req = '0;
  jlm_pkg::jlm_octets_t [3:0] out_lanes;
  int fails = 0, total_checks = 0, n, seed = 32'h5E44, inv = 0, src[4] = '{0, 1, 2, 3};
  always #2.5 sys_clk = ~sys_clk;
  jlm_rx_link #(.LMFC_PERIOD(8), .ROT_CYCLES(2)) DUT (.sys_clk(sys_clk), .rst(rst), .reg_req(req),
    .reg_rdata(reg_rdata), .lane_valid(lane_valid), .lane_sym(lane_sym), .lane_ready(lane_ready),
    .sysref(sysref), .subclass_one(sc1), .out_valid(out_valid), .out_lanes(out_lanes),
    .out_ready(out_ready), .fifo_irq(fifo_irq), .lmfc_edge(lmfc_edge));
  jlm_tx_model tx (.sys_clk(sys_clk), .send(send), .pulse(pulse), .lane_ready(lane_ready),
    .lane_valid(lane_valid), .lane_sym(lane_sym), .sent_idx(sent_idx), .sysref(sysref));
  task automatic check(string what, logic [159:0] seen, logic [159:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic reg_op(logic wr, logic [11:0] a, logic [7:0] d);
    @(posedge sys_clk) #1 req = '{wr, !wr, a, d};
    @(posedge sys_clk) #1 req = '0;
    rd = reg_rdata;
  endtask
  task automatic rd_chk(string what, logic [11:0] a, logic [7:0] exp);
    reg_op(0, a, 0);
    check(what, rd, exp);
  endtask
  // One SYSREF pulse, acted on three edges after it is raised
  task automatic strobe;
    @(posedge sys_clk) #1 pulse = 1;
    @(posedge sys_clk) #1 pulse = 0;
    repeat (6) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    if (!rst && lane_valid == 4'hF && lane_ready == 4'hF) q.push_back(sent_idx);
    if (!rst && out_valid && out_ready && q.size() > 0) begin
      e = q.pop_front();
      ex = '0;
      for (int l = 0; l < 4; l++)
        for (int j = 0; j < 4; j++)
          ex[l][8*j +: 8] = DATA[8*(((e[2*src[l] +: 2] + j) % 4) ^ inv[l]) +: 8];
      check("out_lanes", out_lanes, ex);
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 rst = 0;
    rd_chk("xbar01", 12'h308, 8'h08);
    rd_chk("xbar23", 12'h309, 8'h1A);
    reg_op(1, 12'h308, 8'h1A);
    reg_op(1, 12'h309, 8'h08);
    src = '{2, 3, 0, 1};
    inv = $random(seed) & 15;
    reg_op(1, 12'h334, 8'(inv));
    reg_op(1, 12'h01F, 8'h02);
    send = 1;
    repeat (40) @(posedge sys_clk) #1 out_ready = 1'($random(seed));
    out_ready = 0;
    for (n = 0; n < 50 && lane_ready != 4'h0; n++) @(posedge sys_clk);
    reg_op(0, 12'h30C, 0);
    check("full", {n < 50, rd}, 9'h10F);
    if (n == 50) report_and_stop();
    check("irq", fifo_irq, 1'b1);
    rd_chk("irq_st", 12'h023, 8'h02);
    send = 0;
    out_ready = 1;
    for (n = 0; n < 50 && q.size() > 0; n++) @(posedge sys_clk);
    reg_op(0, 12'h30D, 0);
    check("empty", {n < 50, rd}, 9'h10F);
    if (n == 50) report_and_stop();
    // Enable still set, so only the clear can drop the interrupt
    reg_op(1, 12'h023, 8'h02);
    check("irq_clr", fifo_irq, 1'b0);
    rd_chk("irq_st_clr", 12'h023, 8'h00);
    reg_op(1, 12'h01F, 8'h00);
    reg_op(1, 12'h034, 8'h00);
    reg_op(1, 12'h03A, 8'hC1);
    // Aligned either way: later phase follows from pulse spacing
    strobe();
    rd_chk("arm", 12'h03A, 8'h81);
    reg_op(0, 12'h03B, 0);
    check("trip", rd[0], 1'b1);
    rd_chk("cur_err", 12'h03C, 8'h00);
    reg_op(1, 12'h03A, 8'hA1);
    reg_op(0, 12'h03B, 0);
    check("sticky", rd[2:0] & 3'h5, 3'h0);
    strobe();
    reg_op(0, 12'h03B, 0);
    check("unarmed", rd[0], 1'b0);
    rd_chk("unmapped", 12'h7FF, 8'h00);
    reg_op(1, 12'h03A, 8'h89);
    // Pulse 35 cycles after the aligned one: error of 3
    repeat (3) @(posedge sys_clk);
    strobe();
    rd_chk("cur_lo", 12'h03C, 8'h03);
    rd_chk("cur_hi", 12'h03D, 8'h80);
    reg_op(1, 12'h03A, 8'hC9);
    // Pulse 49 cycles after: error of 1, armed so it rotates
    strobe();
    rd_chk("err_snap", 12'h038, 8'h01);
    rd_chk("flag_snap", 12'h039, 8'h80);
    rd_chk("cur_zero", 12'h03C, 8'h00);
    rd_chk("stat", 12'h03B, 8'h0D);
    // continuous mode, one SYSREF pulse in subclass 1; 18 cycles later, error of 2
    reg_op(1, 12'h03A, 8'h82);
    strobe();
    rd_chk("cont_snap", 12'h038, 8'h02);
    sc1 = 0;
    reg_op(1, 12'h03A, 8'hC1);
    repeat (8) @(posedge sys_clk);
    rd_chk("sc0_arm", 12'h03A, 8'h81);
    report_and_stop();
  end
endmodule // test_jesd_rx_lane_map_lmfc_sync
`default_nettype wire
